// ### src/swj_debug_port_mode_switch.sv
`timescale 1ns/1ps
// Summary of operation
// - capture state loads chain, shift moves out
// - shift in from tdi, update loads holding
// - reset sets pins debug, digital, pullup
// - clearing select bits frees pins
// - select writes need unlock and commit
// - ten switches in reset trigger erase
// - tap preamble walk enables serial wire
// - value e79e switches to serial wire
// - fifty ones in serial wire: line reset
// - value e73c switches to boundary scan
// - five ones leave tap in reset
// - mode line sampled on rising clock
// - five high mode bits reset tap
// - test reset low holds tap reset
module swj_debug_port_mode_switch (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   // debug pins
   input  wire logic                     tck_pin,
   input  wire logic                     tms_pin,
   input  wire logic                     tdi_pin,
   input  wire logic                     trst_n_pin,
   input  wire logic                     ext_rst_n_pin,
   output logic                          tdo_out,
   output logic                          tdo_oe,
   // data chain user side
   input  wire logic [swj_pkg::DR_LEN-1:0] dr_capture_data,
   output logic [swj_pkg::DR_LEN-1:0]      dr_update_data,
   output logic                          dr_update_pulse,
   output logic [swj_pkg::IR_LEN-1:0]      ir_current,
   // pin configuration writes
   input  wire logic                     afsel_wr,
   input  wire logic [4:0]               afsel_wdata,
   input  wire logic                     lock_wr,
   input  wire logic [31:0]              lock_wdata,
   input  wire logic                     commit_wr,
   input  wire logic [4:0]               commit_wdata,
   // pin configuration state
   output logic [4:0]                    pin_alt_function_select,
   output logic [4:0]                    pin_digital_enable,
   output logic [4:0]                    pin_pullup_enable,
   output logic [4:0]                    pin_config_commit,
   output logic                          pin_config_unlocked,
   // port status
   output logic                          swd_mode,
   output logic                          swd_line_reset,
   output logic                          mass_erase_req
);
   import swj_pkg::*;

   // =====================================================================
   // pin synchronisers
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic       tck_prev_q;
   logic       ext_prev_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync1_q <= 5'h1f;
         sync2_q <= 5'h1f;
      end else if (clk_en) begin
         sync1_q <= {ext_rst_n_pin, trst_n_pin, tdi_pin, tms_pin, tck_pin};
         sync2_q <= sync1_q;
      end
   end

   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic trst_n_s;
   logic ext_rst_n_s;
   assign tck_s       = sync2_q[0];
   assign tms_s       = sync2_q[1];
   assign tdi_s       = sync2_q[2];
   assign trst_n_s    = sync2_q[3];
   assign ext_rst_n_s = sync2_q[4];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tck_prev_q <= 1'b1;
         ext_prev_q <= 1'b1;
      end else if (clk_en) begin
         tck_prev_q <= tck_s;
         ext_prev_q <= ext_rst_n_s;
      end
   end

   logic tck_rise;
   logic tck_fall;
   assign tck_rise = clk_en && tck_s && !tck_prev_q;
   assign tck_fall = clk_en && !tck_s && tck_prev_q;

   // =====================================================================
   // switch value detector
   logic to_swd;
   logic to_jtag;
   logic ones_long;

   switch_seq_detect u_detect (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .clk_en        (clk_en),
      .bit_valid     (tck_rise),
      .bit_value     (tms_s),
      .to_swd_pulse  (to_swd),
      .to_jtag_pulse (to_jtag),
      .ones_long     (ones_long)
   );

   // =====================================================================
   // tap controller
   function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
      case (s)
         TLR:      tap_next = m ? TLR      : RTI;
         RTI:      tap_next = m ? SEL_DR   : RTI;
         SEL_DR:   tap_next = m ? SEL_IR   : CAP_DR;
         CAP_DR:   tap_next = m ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: tap_next = m ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: tap_next = m ? UPD_DR   : PAUSE_DR;
         PAUSE_DR: tap_next = m ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: tap_next = m ? UPD_DR   : SHIFT_DR;
         UPD_DR:   tap_next = m ? SEL_DR   : RTI;
         SEL_IR:   tap_next = m ? TLR      : CAP_IR;
         CAP_IR:   tap_next = m ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: tap_next = m ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: tap_next = m ? UPD_IR   : PAUSE_IR;
         PAUSE_IR: tap_next = m ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: tap_next = m ? UPD_IR   : SHIFT_IR;
         UPD_IR:   tap_next = m ? SEL_DR   : RTI;
         default:  tap_next = TLR;
      endcase
   endfunction : tap_next

   // state walk that hands the port to serial wire
   // one idle first, then select dr, select ir, reset, reset, then idle, idle, select dr, select ir, reset, reset, then idle, idle, select dr, select ir, reset
   function automatic tap_state_t preamble_step(input logic [3:0] i);
      case (i)
         4'h0, 4'h5, 4'h6, 4'hb, 4'hc: preamble_step = RTI;
         4'h1, 4'h7, 4'hd:             preamble_step = SEL_DR;
         4'h2, 4'h8, 4'he:             preamble_step = SEL_IR;
         default:                      preamble_step = TLR;
      endcase
   endfunction : preamble_step

   port_mode_t mode_q;
   tap_state_t state_q;
   tap_state_t state_d;
   logic [3:0] pre_cnt_q;
   logic       pre_hit;

   assign state_d = tap_next(state_q, tms_s);
   assign pre_hit = tck_rise && mode_q == MODE_JTAG && trst_n_s
                    && pre_cnt_q == PREAMBLE_LAST && state_d == preamble_step(PREAMBLE_LAST);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= TLR;
      end else if (clk_en) begin
         if (!trst_n_s || to_jtag || mode_q == MODE_SWD) begin
            state_q <= TLR;
         end else if (tck_rise) begin
            state_q <= state_d;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pre_cnt_q <= 4'h0;
      end else if (clk_en && tck_rise) begin
         if (mode_q != MODE_JTAG || !trst_n_s) begin
            pre_cnt_q <= 4'h0;
         end else if (state_d == preamble_step(pre_cnt_q)
                      && (pre_cnt_q != 4'h0 || state_q == TLR)) begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
         end else if (state_q == TLR && state_d == RTI) begin
            pre_cnt_q <= 4'h1;
         end else begin
            pre_cnt_q <= 4'h0;
         end
      end
   end

   // =====================================================================
   // port mode
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_q <= MODE_JTAG;
      end else if (clk_en) begin
         if (to_swd || pre_hit) begin
            mode_q <= MODE_SWD;
         end else if (to_jtag) begin
            mode_q <= MODE_JTAG;
         end
      end
   end

   assign swd_mode       = (mode_q == MODE_SWD);
   assign swd_line_reset = swd_mode && ones_long;

   // =====================================================================
   // scan chains
   logic [IR_LEN-1:0] ir_shift_q;
   logic [IR_LEN-1:0] ir_q;
   logic [DR_LEN-1:0] dr_shift_q;
   logic [DR_LEN-1:0] dr_hold_q;
   logic              dr_upd_q;
   logic              tdo_q;
   logic              tdo_oe_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ir_shift_q <= IR_CAPTURE;
         dr_shift_q <= '0;
      end else if (tck_rise && mode_q == MODE_JTAG) begin
         case (state_q)
            CAP_IR:   ir_shift_q <= IR_CAPTURE;
            SHIFT_IR: ir_shift_q <= {tdi_s, ir_shift_q[IR_LEN-1:1]};
            CAP_DR:   dr_shift_q <= dr_capture_data;
            SHIFT_DR: dr_shift_q <= {tdi_s, dr_shift_q[DR_LEN-1:1]};
            default:  ir_shift_q <= ir_shift_q;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ir_q      <= IR_DEFAULT;
         dr_hold_q <= '0;
         dr_upd_q  <= 1'b0;
      end else if (clk_en) begin
         dr_upd_q <= tck_fall && state_q == UPD_DR;
         if (state_q == TLR) begin
            ir_q <= IR_DEFAULT;
         end else if (tck_fall && state_q == UPD_IR) begin
            ir_q <= ir_shift_q;
         end
         if (tck_fall && state_q == UPD_DR) begin
            dr_hold_q <= dr_shift_q;
         end
      end
   end

   // tdo changes on the falling edge, idle otherwise
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_q <= state_q == SHIFT_DR || state_q == SHIFT_IR;
         tdo_q    <= (state_q == SHIFT_IR) ? ir_shift_q[0] : dr_shift_q[0];
      end
   end

   assign tdo_out         = tdo_q;
   assign tdo_oe          = tdo_oe_q;
   assign ir_current      = ir_q;
   assign dr_update_data  = dr_hold_q;
   assign dr_update_pulse = dr_upd_q;

   // =====================================================================
   // pin configuration with lock and commit
   logic       pin_rst;
   logic       unlocked_q;
   logic [4:0] commit_q;
   logic [4:0] afsel_q;
   logic [4:0] den_q;
   logic [4:0] pur_q;

   assign pin_rst = sys_rst || !ext_rst_n_s;

   always_ff @(posedge clock) begin
      if (pin_rst) begin
         unlocked_q <= 1'b0;
         commit_q   <= 5'h00;
         afsel_q    <= PIN_RESET;
         den_q      <= PIN_RESET;
         pur_q      <= PIN_RESET;
      end else if (clk_en) begin
         if (lock_wr) begin
            unlocked_q <= (lock_wdata == LOCK_KEY);
         end
         if (commit_wr && unlocked_q) begin
            commit_q <= commit_wdata;
         end
         if (afsel_wr && unlocked_q) begin
            afsel_q <= (afsel_wdata & commit_q) | (afsel_q & ~commit_q);
         end
      end
   end

   assign pin_alt_function_select = afsel_q;
   assign pin_digital_enable      = den_q;
   assign pin_pullup_enable       = pur_q;
   assign pin_config_commit       = commit_q;
   assign pin_config_unlocked     = unlocked_q;

   // =====================================================================
   // locked device recovery
   logic [3:0] rec_cnt_q;
   logic       erase_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rec_cnt_q <= 4'h0;
         erase_q   <= 1'b0;
      end else if (clk_en) begin
         erase_q <= ext_rst_n_s && !ext_prev_q && rec_cnt_q >= RECOVER_SWITCHES;
         if (ext_rst_n_s) begin
            rec_cnt_q <= 4'h0;
         end else if ((to_swd && !rec_cnt_q[0]) || (to_jtag && rec_cnt_q[0])) begin
            if (rec_cnt_q != RECOVER_MAX) begin
               rec_cnt_q <= rec_cnt_q + 4'h1;
            end
         end else if (to_swd || to_jtag) begin
            rec_cnt_q <= {3'h0, to_swd};
         end
      end
   end

   assign mass_erase_req = erase_q;

   // =====================================================================
   // checks
   logic [2:0] high_cnt_q;
   always_ff @(posedge clock) begin
      if (sys_rst || mode_q != MODE_JTAG) begin
         high_cnt_q <= 3'h0;
      end else if (tck_rise) begin
         high_cnt_q <= !tms_s ? 3'h0 : (high_cnt_q == FIVE_ONES) ? high_cnt_q
                                                              : high_cnt_q + 3'h1;
      end
   end

   AST_POR_PINS: assert property (@(posedge clock)
      sys_rst |=> afsel_q == PIN_RESET && den_q == PIN_RESET && pur_q == PIN_RESET)
      else $error("pins not restored to debug use");
   AST_POR_MODE: assert property (@(posedge clock) sys_rst |=> mode_q == MODE_JTAG)
      else $error("port not in boundary scan after reset");
   AST_TRST_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && !trst_n_s |=> state_q == TLR)
      else $error("test reset did not hold tap reset");
   AST_FIVE_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
      high_cnt_q == FIVE_ONES |-> state_q == TLR ##1 ir_q == IR_DEFAULT)
      else $error("five high mode bits did not reset tap");
   AST_CAPTURE: assert property (@(posedge clock) disable iff (sys_rst)
      tck_rise && mode_q == MODE_JTAG && state_q == CAP_DR |=> dr_shift_q == $past(dr_capture_data))
      else $error("capture did not load chain");
   AST_SHIFT: assert property (@(posedge clock) disable iff (sys_rst)
      tck_rise && mode_q == MODE_JTAG && state_q == SHIFT_DR
      |=> dr_shift_q == {$past(tdi_s), $past(dr_shift_q[DR_LEN-1:1])})
      else $error("shift did not take tdi");
   AST_UPDATE: assert property (@(posedge clock) disable iff (sys_rst)
      dr_upd_q |-> dr_hold_q == dr_shift_q && $past(state_q) == UPD_DR)
      else $error("update did not copy chain");
   AST_LOCKED: assert property (@(posedge clock) disable iff (pin_rst)
      afsel_wr && !unlocked_q |=> $stable(afsel_q))
      else $error("locked select write took effect");
   AST_SWITCH: assert property (@(posedge clock) disable iff (sys_rst)
      to_swd |=> mode_q == MODE_SWD ##1 state_q == TLR)
      else $error("swd switch not taken");
   AST_TO_JTAG: assert property (@(posedge clock) disable iff (sys_rst)
      to_jtag && !to_swd |=> mode_q == MODE_JTAG && state_q == TLR)
      else $error("jtag switch not taken");
   AST_ERASE: assert property (@(posedge clock) disable iff (sys_rst)
      erase_q |-> $past(rec_cnt_q) >= RECOVER_SWITCHES && $past(ext_rst_n_s))
      else $error("erase without ten switches");

endmodule : swj_debug_port_mode_switch

// ### src/swj_pkg.sv
package swj_pkg;

   // =====================================================================
   // widths and codes
   localparam int          PIN_COUNT        = 5;
   localparam logic [4:0]  PIN_RESET        = 5'h1f;
   localparam logic [31:0] LOCK_KEY         = 32'h0000_c0de; // arbitrary unlock key
   localparam int          IR_LEN           = 4;
   localparam logic [3:0]  IR_DEFAULT       = 4'he;
   localparam logic [3:0]  IR_CAPTURE       = 4'h1;
   localparam int          DR_LEN           = 32;
   localparam logic [15:0] SWITCH_TO_SWD    = 16'he79e;
   localparam logic [15:0] SWITCH_TO_JTAG   = 16'he73c;
   localparam logic [3:0]  SWITCH_LAST_BIT  = 4'hf;
   localparam logic [5:0]  ONES_MIN         = 6'h32;
   localparam logic [3:0]  RECOVER_SWITCHES = 4'ha;
   localparam logic [3:0]  RECOVER_MAX      = 4'hf;
   localparam logic [3:0]  PREAMBLE_LAST    = 4'hf;
   localparam logic [2:0]  FIVE_ONES        = 3'h5;

   // =====================================================================
   // state types
   typedef enum logic [15:0] {
      TLR       = 16'h0001,
      RTI       = 16'h0002,
      SEL_DR    = 16'h0004,
      CAP_DR    = 16'h0008,
      SHIFT_DR  = 16'h0010,
      EXIT1_DR  = 16'h0020,
      PAUSE_DR  = 16'h0040,
      EXIT2_DR  = 16'h0080,
      UPD_DR    = 16'h0100,
      SEL_IR    = 16'h0200,
      CAP_IR    = 16'h0400,
      SHIFT_IR  = 16'h0800,
      EXIT1_IR  = 16'h1000,
      PAUSE_IR  = 16'h2000,
      EXIT2_IR  = 16'h4000,
      UPD_IR    = 16'h8000
   } tap_state_t;

   typedef enum logic [1:0] {
      MODE_JTAG = 2'b01,
      MODE_SWD  = 2'b10
   } port_mode_t;

endpackage : swj_pkg

// ### src/switch_seq_detect.sv
`timescale 1ns/1ps
module switch_seq_detect (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // sampled mode/data line
   input  wire logic bit_valid,
   input  wire logic bit_value,
   // detected events
   output logic      to_swd_pulse,
   output logic      to_jtag_pulse,
   output logic      ones_long
);
   import swj_pkg::*;

   logic [5:0]  ones_q;
   logic        armed_q;
   logic [3:0]  cnt_q;
   logic [15:0] sr_q;
   logic [15:0] word;

   assign word      = {bit_value, sr_q[15:1]};
   assign ones_long = (ones_q == ONES_MIN);

   // =====================================================================
   // run of ones before a switch value, saturating
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ones_q <= 6'h00;
      end else if (clk_en && bit_valid) begin
         if (!bit_value) begin
            ones_q <= 6'h00;
         end else if (ones_q != ONES_MIN) begin
            ones_q <= ones_q + 6'h01;
         end
      end
   end

   // =====================================================================
   // 16-bit value collector, lsb first, armed by the first zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         armed_q <= 1'b0;
         cnt_q   <= 4'h0;
         sr_q    <= 16'h0000;
      end else if (clk_en && bit_valid) begin
         sr_q <= word;
         if (armed_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == SWITCH_LAST_BIT) begin
               armed_q <= 1'b0;
            end
         end else if (!bit_value && ones_long) begin
            armed_q <= 1'b1;
            cnt_q   <= 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         to_swd_pulse  <= 1'b0;
         to_jtag_pulse <= 1'b0;
      end else if (clk_en) begin
         to_swd_pulse  <= bit_valid && armed_q && cnt_q == SWITCH_LAST_BIT
                          && word == SWITCH_TO_SWD;
         to_jtag_pulse <= bit_valid && armed_q && cnt_q == SWITCH_LAST_BIT
                          && word == SWITCH_TO_JTAG;
      end
   end

   // =====================================================================
   // checks
   sequence seq_final_bit;
      clk_en && bit_valid && armed_q && cnt_q == SWITCH_LAST_BIT;
   endsequence

   AST_SWD_VALUE: assert property (@(posedge clock) disable iff (sys_rst)
      seq_final_bit ##0 (word == SWITCH_TO_SWD) |=> to_swd_pulse)
      else $error("swd switch value not reported");
   AST_JTAG_VALUE: assert property (@(posedge clock) disable iff (sys_rst)
      to_jtag_pulse |-> $past(word) == SWITCH_TO_JTAG && $past(cnt_q) == SWITCH_LAST_BIT)
      else $error("jtag switch reported without its value");

endmodule : switch_seq_detect

// ### bench/debug_probe_model.sv
`timescale 1ns/1ps
// =====================================================================
// external probe: drives test clock, mode/data and data-in lines
module debug_probe_model (
   // clock
   input  wire logic clock,
   // link
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic [31:0] got_q;

   // idle at pull-up level, clock stands still between frames
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
      got_q = 32'h0;
   end

   // one test clock period, lines moved only at the fall
   task automatic cyc(input logic m, input logic d);
      @(posedge clock);
      #1;
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(posedge clock);
      #1;
      tck = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      got_q = {tdo, got_q[31:1]};
   endtask : cyc

   task automatic ones(input int n);
      for (int i = 0; i < n; i++) begin
         cyc(1'b1, 1'b1);
      end
   endtask : ones

   task automatic send16(input logic [15:0] val);
      for (int i = 0; i < 16; i++) begin
         cyc(val[i], 1'b1);
      end
   endtask : send16

   // leading ones and value only, trailing ones left out
   task automatic switch_seq(input logic [15:0] val);
      ones(50);
      send16(val);
   endtask : switch_seq
endmodule : debug_probe_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import swj_pkg::*;
   // =====================================================================
   // signals
   logic        clock, sys_rst, clk_en, tck, tms, tdi, trst_n, ext_rst_n, tdo_out, tdo_oe;
   logic        upd_pulse, afsel_wr, lock_wr, commit_wr, unlocked, swd_mode, line_rst, erase;
   logic [31:0] dr_cap, dr_upd, lock_wdata, v;
   logic [4:0]  afsel_wdata, commit_wdata, afsel, den, pur, commit;
   logic [3:0]  ir;
   int          errors, n_tests, n_upd, n_erase;
   wire         tdo_line = tdo_oe ? tdo_out : 1'b1;

   initial clock = 1'b0;
   always #12.5 clock = ~clock;

   always @(posedge clock) begin
      if (upd_pulse === 1'b1) begin
         n_upd++;
      end
      if (erase === 1'b1) begin
         n_erase++;
      end
   end

   swj_debug_port_mode_switch swj_debug_port_mode_switch_i (
      .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
      .trst_n_pin(trst_n), .ext_rst_n_pin(ext_rst_n),
      .tdo_out(tdo_out), .tdo_oe(tdo_oe),
      .dr_capture_data(dr_cap), .dr_update_data(dr_upd),
      .dr_update_pulse(upd_pulse), .ir_current(ir),
      .afsel_wr(afsel_wr), .afsel_wdata(afsel_wdata),
      .lock_wr(lock_wr), .lock_wdata(lock_wdata),
      .commit_wr(commit_wr), .commit_wdata(commit_wdata),
      .pin_alt_function_select(afsel), .pin_digital_enable(den),
      .pin_pullup_enable(pur), .pin_config_commit(commit),
      .pin_config_unlocked(unlocked), .swd_mode(swd_mode),
      .swd_line_reset(line_rst), .mass_erase_req(erase)
   );

   debug_probe_model debug_probe_model_i (
      .clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line)
   );

   // =====================================================================
   // tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : idle

   // kind 0 select, 1 lock, 2 commit
   task automatic wr(input int kind, input logic [31:0] val);
      idle(1);
      afsel_wr = (kind == 0);
      lock_wr = (kind == 1);
      commit_wr = (kind == 2);
      afsel_wdata = val[4:0];
      lock_wdata = val;
      commit_wdata = val[4:0];
      idle(1);
      afsel_wr = 1'b0;
      lock_wr = 1'b0;
      commit_wr = 1'b0;
   endtask : wr

   // from reset or idle: capture, shift len bits, update, back to idle
   task automatic scan(input logic is_ir, input logic [31:0] din, input int len,
                       output logic [31:0] dout);
      debug_probe_model_i.cyc(1'b0, 1'b1);
      debug_probe_model_i.cyc(1'b1, 1'b1);
      if (is_ir) begin
         debug_probe_model_i.cyc(1'b1, 1'b1);
      end
      debug_probe_model_i.cyc(1'b0, 1'b1);
      debug_probe_model_i.cyc(1'b0, 1'b1);
      for (int i = 0; i < len; i++) begin
         debug_probe_model_i.cyc(i == len - 1, din[i]);
      end
      dout = debug_probe_model_i.got_q >> (32 - len);
      debug_probe_model_i.cyc(1'b1, 1'b1);
      debug_probe_model_i.cyc(1'b0, 1'b1);
      idle(4);
   endtask : scan

   // alternating switches while held in external reset
   task automatic recover(input int n);
      ext_rst_n = 1'b0;
      idle(4);
      for (int i = 0; i < n; i++) begin
         debug_probe_model_i.switch_seq(i % 2 ? SWITCH_TO_JTAG : SWITCH_TO_SWD);
      end
      chk("afsel in ext reset", PIN_RESET, afsel);
      ext_rst_n = 1'b1;
   endtask : recover

   // =====================================================================
   // main sequence
   initial begin
      {sys_rst, clk_en, trst_n, ext_rst_n} = 4'hf;
      {afsel_wr, lock_wr, commit_wr} = 3'h0;
      {afsel_wdata, commit_wdata, lock_wdata} = 42'h0;
      dr_cap = 32'ha5c3_0f96;
      {errors, n_tests, n_upd, n_erase} = '0;
      repeat (4) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      idle(4);
      chk("afsel", PIN_RESET, afsel);
      chk("den", PIN_RESET, den);
      chk("pur", PIN_RESET, pur);
      chk("mode", 1'b0, swd_mode);
      chk("ir", IR_DEFAULT, ir);
      $display("test reset_defaults done");
      wr(0, 32'h0);
      idle(2);
      chk("afsel locked", PIN_RESET, afsel);
      wr(1, LOCK_KEY);
      wr(2, 32'h05);
      wr(0, 32'h0);
      idle(2);
      chk("unlocked", 1'b1, unlocked);
      chk("commit", 5'h05, commit);
      chk("afsel partial", 5'h1a, afsel);
      wr(2, 32'h1f);
      wr(0, 32'h0);
      idle(2);
      chk("afsel free", 5'h00, afsel);
      wr(0, 32'h15);
      wr(1, 32'h0);
      wr(0, 32'h1f);
      idle(2);
      chk("afsel relocked", 5'h15, afsel);
      chk("locked", 1'b0, unlocked);
      $display("test pin_config done");
      scan(1'b0, 32'h1234_5678, 32, v);
      chk("tdo dr", dr_cap, v);
      chk("dr update", 32'h1234_5678, dr_upd);
      chk("update pulses", 1, n_upd);
      chk("tdo idle", 1'b0, tdo_oe);
      scan(1'b1, 32'h2, 4, v);
      chk("tdo ir", IR_CAPTURE, v);
      chk("ir loaded", 4'h2, ir);
      clk_en = 1'b0;
      debug_probe_model_i.ones(5);
      clk_en = 1'b1;
      idle(4);
      chk("ir frozen", 4'h2, ir);
      debug_probe_model_i.ones(5);
      idle(4);
      chk("ir five ones", IR_DEFAULT, ir);
      trst_n = 1'b0;
      scan(1'b1, 32'h8, 4, v);
      chk("ir test reset", IR_DEFAULT, ir);
      trst_n = 1'b1;
      idle(4);
      $display("test scan done");
      debug_probe_model_i.switch_seq(SWITCH_TO_SWD);
      idle(4);
      chk("mode swd", 1'b1, swd_mode);
      scan(1'b1, 32'h3, 4, v);
      chk("ir in swd", IR_DEFAULT, ir);
      chk("line reset early", 1'b0, line_rst);
      debug_probe_model_i.ones(45);
      idle(4);
      chk("line reset 45", 1'b0, line_rst);
      debug_probe_model_i.ones(5);
      idle(4);
      chk("line reset 50", 1'b1, line_rst);
      debug_probe_model_i.switch_seq(SWITCH_TO_JTAG);
      idle(4);
      chk("mode jtag", 1'b0, swd_mode);
      debug_probe_model_i.ones(5);
      scan(1'b1, 32'h2, 4, v);
      chk("ir after switch", 4'h2, ir);
      dr_cap = 32'h0ff0_5aa5;
      scan(1'b0, 32'h8765_4321, 32, v);
      chk("tdo dr again", 32'h0ff0_5aa5, v);
      chk("dr update again", 32'h8765_4321, dr_upd);
      $display("test switch done");
      // tap walk pattern with only five ones ahead of it
      debug_probe_model_i.ones(5);
      debug_probe_model_i.send16(16'he79e);
      idle(4);
      chk("mode preamble", 1'b1, swd_mode);
      debug_probe_model_i.switch_seq(SWITCH_TO_JTAG);
      debug_probe_model_i.ones(5);
      $display("test preamble done");
      recover(9);
      idle(20);
      chk("erase nine", 0, n_erase);
      recover(10);
      for (int i = 0; i < 20 && n_erase == 0; i++) begin
         idle(1);
      end
      idle(4);
      chk("erase ten", 1, n_erase);
      $display("test recovery done");
      stop_test();
   end

   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      stop_test();
   end
endmodule : tb_top
